// ### hdl/ppc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ppc_sync #(
    parameter int WIDTH = 32
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_q;

    if (WIDTH < 1) begin : g_chk
        $error("ppc_sync: WIDTH must be at least 1");
    end

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage1_q <= '0;
            sync_out <= '0;
        end else begin
            stage1_q <= async_in;
            sync_out <= stage1_q;
        end
    end
endmodule : ppc_sync
`default_nettype wire

// ### hdl/ppc_top.sv
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module ppc_top #(
    parameter int ADDR_W = 18
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [15:0]       p2_pin_in,
    output logic [15:0]            p2_pin_out,
    output logic [15:0]            p2_pin_oe_n,
    input  wire logic [15:0]       port3_pin_in,
    output logic [15:0]            port3_pin_out,
    output logic [15:0]            port3_pin_oe_n,
    input  wire logic [15:0]       compare_strobe,
    input  wire logic [15:0]       cc_mode3,
    input  wire logic [15:0]       cc_overflow,
    output logic [15:0]            alt_pin_in,
    output logic [15:0]            alt_latch_readback,
    output logic [15:0]            alt_out_line,
    output logic [15:0]            ext_irq_sample,
    output logic [7:0]             fast_ext_irq_input,
    output logic                   timer7_count_input
);
    if (ADDR_W < 18 || ADDR_W > 32) begin : g_chk
        $error("ppc_top: ADDR_W must lie in 18..32");
    end

    logic [15:0]      p2_q, p2_dir_q, p2_od_q, port3_q, port3_dir_q, port3_od_q;
    logic [15:0]      p2_d;
    logic [15:0]      p2_sync, port3_sync;
    logic             aw_full_q, w_full_q;
    logic [15:0]      aw_idx_q;
    logic [15:0]      wdata_q;
    logic [1:0]       wstrb_q;
    logic             do_wr;
    ppc_pkg::ppc_reg_t wr_sel, rd_sel;
    logic [15:0]      cpu_mask, tog_bits, set_bits, clr_bits;
    logic [7:0]       slow_cnt_q, fast_cnt_q;

    ppc_sync #(.WIDTH(32)) u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in ({port3_pin_in, p2_pin_in}),
        .sync_out ({port3_sync, p2_sync})
    );

    // AXI4-Lite write side: address and data taken in either order
    assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
    assign do_wr         = aw_full_q && w_full_q && !s_axi_bvalid;
    assign wr_sel        = ppc_pkg::ppc_decode(aw_idx_q);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_full_q <= 1'b0;
            aw_idx_q  <= 16'h0000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            aw_idx_q  <= s_axi_awaddr[17:2];
        end else if (do_wr) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            w_full_q <= 1'b0;
            wdata_q  <= 16'h0000;
            wstrb_q  <= 2'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            wdata_q  <= s_axi_wdata[15:0];
            wstrb_q  <= s_axi_wstrb[1:0];
        end else if (do_wr) begin
            w_full_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= ppc_pkg::RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_sel == ppc_pkg::REG_NONE) ? ppc_pkg::RESP_SLVERR
                                                          : ppc_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // First-port latch: hardware compare updates and CPU writes
    assign cpu_mask = (do_wr && wr_sel == ppc_pkg::REG_P2_DATA)
                    ? {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}} : 16'h0000;
    assign tog_bits = compare_strobe & ~cc_mode3;
    assign set_bits = compare_strobe & cc_mode3 & ~cc_overflow;
    assign clr_bits = compare_strobe & cc_mode3 & cc_overflow;
    assign alt_latch_readback = p2_q;
    assign alt_out_line       = (~alt_latch_readback & tog_bits) | set_bits;

    always_comb begin
        p2_d = (p2_q & ~compare_strobe) | (alt_out_line & compare_strobe);
        p2_d = (p2_d & ~cpu_mask) | (wdata_q & cpu_mask);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            p2_q <= ppc_pkg::RST_P2_DATA;
        end else begin
            p2_q <= p2_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            p2_dir_q <= ppc_pkg::RST_P2_DIR;
            p2_od_q  <= ppc_pkg::RST_P2_OD;
        end else if (do_wr && wr_sel == ppc_pkg::REG_P2_DIR) begin
            p2_dir_q <= ppc_pkg::ppc_merge(p2_dir_q, wdata_q, wstrb_q, 16'hFFFF);
        end else if (do_wr && wr_sel == ppc_pkg::REG_P2_OD) begin
            p2_od_q  <= ppc_pkg::ppc_merge(p2_od_q, wdata_q, wstrb_q, 16'hFFFF);
        end
    end

    // Second-port registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            port3_q     <= ppc_pkg::RST_PORT3_DATA;
            port3_dir_q <= ppc_pkg::RST_PORT3_DIR;
            port3_od_q  <= ppc_pkg::RST_PORT3_OD;
        end else if (do_wr) begin
            if (wr_sel == ppc_pkg::REG_PORT3_DATA) begin
                port3_q <= ppc_pkg::ppc_merge(port3_q, wdata_q, wstrb_q,
                                              ppc_pkg::MASK_PORT3_DATA);
            end else if (wr_sel == ppc_pkg::REG_PORT3_DIR) begin
                port3_dir_q <= ppc_pkg::ppc_merge(port3_dir_q, wdata_q, wstrb_q,
                                                  ppc_pkg::MASK_PORT3_DIR);
            end else if (wr_sel == ppc_pkg::REG_PORT3_OD) begin
                port3_od_q <= ppc_pkg::ppc_merge(port3_od_q, wdata_q, wstrb_q,
                                                 ppc_pkg::MASK_PORT3_OD);
            end
        end
    end

    // Pin drivers; open-drain releases the pin to send a one
    assign p2_pin_out = p2_q;
    assign p2_pin_oe_n = ~(p2_dir_q & (~p2_od_q | ~p2_q));
    assign port3_pin_out  = port3_q & ppc_pkg::MASK_PORT3_DATA;
    assign port3_pin_oe_n = ~(port3_dir_q & (~port3_od_q | ~port3_q)
                              & ppc_pkg::MASK_PORT3_DATA);

    assign alt_pin_in = (p2_dir_q & p2_q) | (~p2_dir_q & p2_sync);
    assign timer7_count_input = alt_pin_in[ppc_pkg::HW_TIMER_LINE];

    // Sample-rate dividers; the clock is slower than the documented base
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slow_cnt_q <= 8'h00;
        end else if (slow_cnt_q == 8'(ppc_pkg::SLOW_CYC - 1)) begin
            slow_cnt_q <= 8'h00;
        end else begin
            slow_cnt_q <= slow_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fast_cnt_q <= 8'h00;
        end else if (fast_cnt_q == 8'(ppc_pkg::FAST_CYC - 1)) begin
            fast_cnt_q <= 8'h00;
        end else begin
            fast_cnt_q <= fast_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_irq_sample     <= 16'h0000;
            fast_ext_irq_input <= 8'h00;
        end else begin
            if (slow_cnt_q == 8'(ppc_pkg::SLOW_CYC - 1)) begin
                ext_irq_sample <= alt_pin_in;
            end
            if (fast_cnt_q == 8'(ppc_pkg::FAST_CYC - 1)) begin
                fast_ext_irq_input <= alt_pin_in[15:8];
            end
        end
    end

    // AXI4-Lite read side; data registers read back the latch for output bits, the synchronised pin for input bits
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_sel        = ppc_pkg::ppc_decode(s_axi_araddr[17:2]);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= ppc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= ppc_pkg::RESP_OKAY;
            if (rd_sel == ppc_pkg::REG_P2_DATA) begin
                s_axi_rdata <= {16'h0000, alt_pin_in};
            end else if (rd_sel == ppc_pkg::REG_P2_DIR) begin
                s_axi_rdata <= {16'h0000, p2_dir_q};
            end else if (rd_sel == ppc_pkg::REG_P2_OD) begin
                s_axi_rdata <= {16'h0000, p2_od_q};
            end else if (rd_sel == ppc_pkg::REG_PORT3_DATA) begin
                s_axi_rdata <= {16'h0000,
                                ((port3_dir_q & port3_q) | (~port3_dir_q & port3_sync))
                                & ppc_pkg::MASK_PORT3_DATA};
            end else if (rd_sel == ppc_pkg::REG_PORT3_DIR) begin
                s_axi_rdata <= {16'h0000, port3_dir_q};
            end else if (rd_sel == ppc_pkg::REG_PORT3_OD) begin
                s_axi_rdata <= {16'h0000, port3_od_q};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= ppc_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_toggle_bits: assert property (
        (|(tog_bits & ~cpu_mask)) |=>
        (((p2_q ^ $past(p2_q)) & $past(tog_bits & ~cpu_mask)) == $past(tog_bits & ~cpu_mask)))
        else $error("mode 1 strobe did not toggle latch");
    chk_mode3_set: assert property (
        (|(set_bits & ~cpu_mask)) |=>
        ((p2_q & $past(set_bits & ~cpu_mask)) == $past(set_bits & ~cpu_mask)))
        else $error("mode 3 match did not set latch");
    chk_mode3_clear: assert property (
        (|(clr_bits & ~cpu_mask)) |=> ((p2_q & $past(clr_bits & ~cpu_mask)) == 16'h0000))
        else $error("mode 3 overflow did not clear latch");
    chk_idle_hold: assert property (
        (compare_strobe == 16'h0000 && cpu_mask == 16'h0000) |=> $stable(p2_q))
        else $error("latch changed without strobe or write");
    chk_cpu_priority: assert property (
        (|cpu_mask) |=>
        ((p2_q & $past(cpu_mask)) == ($past(wdata_q) & $past(cpu_mask))))
        else $error("cpu write lost against compare strobe");
    chk_capture_src: assert property (
        ((alt_pin_in & p2_dir_q) == (p2_q & p2_dir_q)) && timer7_count_input == alt_pin_in[15])
        else $error("capture path not showing output latch");
    chk_port3_nopin: assert property (
        port3_pin_oe_n[ppc_pkg::PORT3_NO_PIN] && !port3_pin_out[ppc_pkg::PORT3_NO_PIN])
        else $error("second port bit 14 drives a pin");
    chk_od_release: assert property (
        (|(p2_od_q & p2_q)) |-> ((p2_pin_oe_n & p2_od_q & p2_q) == (p2_od_q & p2_q)))
        else $error("open-drain line driving a one");
    chk_port3_unimpl: assert property (
        ((port3_od_q & ~ppc_pkg::MASK_PORT3_OD) == 16'h0000)
        && ((port3_dir_q & ~ppc_pkg::MASK_PORT3_DIR) == 16'h0000)
        && !port3_q[ppc_pkg::PORT3_NO_PIN])
        else $error("unimplemented second port bit set");
    chk_slow_sample: assert property (
        $changed(ext_irq_sample) |-> ($past(slow_cnt_q) == 8'(ppc_pkg::SLOW_CYC - 1)))
        else $error("slow sample taken off its tick");
endmodule : ppc_top
`default_nettype wire

// ### shared/ppc_pkg.sv
`default_nettype none
package ppc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_P2_DATA = 16'hFFC0;
    localparam logic [15:0] IDX_P2_DIR  = 16'hFFC2;
    localparam logic [15:0] IDX_P2_OD   = 16'hF1C2;
    localparam logic [15:0] IDX_PORT3_DATA = 16'hFFC4;
    localparam logic [15:0] IDX_PORT3_DIR  = 16'hFFC6;
    localparam logic [15:0] IDX_PORT3_OD   = 16'hF1C6;

    localparam logic [15:0] RST_P2_DATA    = 16'h0000;
    localparam logic [15:0] RST_P2_DIR     = 16'h0000;
    localparam logic [15:0] RST_P2_OD      = 16'h0000;
    localparam logic [15:0] RST_PORT3_DATA = 16'h0000;
    localparam logic [15:0] RST_PORT3_DIR  = 16'h0000;
    localparam logic [15:0] RST_PORT3_OD   = 16'h0000;

    // Implemented bit positions of the second port
    localparam logic [15:0] MASK_PORT3_DATA = 16'hBFFF;
    localparam logic [15:0] MASK_PORT3_DIR  = 16'hBFFF;
    localparam logic [15:0] MASK_PORT3_OD   = 16'h2FFF;
    localparam int          PORT3_NO_PIN    = 14;

    localparam int          HW_TIMER_LINE = 15;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Sample periods, in ns, and the derived cycle counts
    localparam int CLK_NS         = 50;
    localparam int SLOW_SAMPLE_NS = 200;
    localparam int FAST_SAMPLE_NS = 25;
    localparam int SLOW_CYC = (SLOW_SAMPLE_NS / CLK_NS < 1) ? 1 : SLOW_SAMPLE_NS / CLK_NS;
    localparam int FAST_CYC = (FAST_SAMPLE_NS / CLK_NS < 1) ? 1 : FAST_SAMPLE_NS / CLK_NS;

    typedef enum logic [2:0] {
        REG_NONE    = 3'b000,
        REG_P2_DATA = 3'b001,
        REG_P2_DIR  = 3'b010,
        REG_P2_OD   = 3'b011,
        REG_PORT3_DATA = 3'b100,
        REG_PORT3_DIR  = 3'b101,
        REG_PORT3_OD   = 3'b110
    } ppc_reg_t;

    function automatic ppc_reg_t ppc_decode(input logic [15:0] idx);
        ppc_reg_t r;
        r = REG_NONE;
        if (idx == IDX_P2_DATA) begin
            r = REG_P2_DATA;
        end else if (idx == IDX_P2_DIR) begin
            r = REG_P2_DIR;
        end else if (idx == IDX_P2_OD) begin
            r = REG_P2_OD;
        end else if (idx == IDX_PORT3_DATA) begin
            r = REG_PORT3_DATA;
        end else if (idx == IDX_PORT3_DIR) begin
            r = REG_PORT3_DIR;
        end else if (idx == IDX_PORT3_OD) begin
            r = REG_PORT3_OD;
        end
        return r;
    endfunction : ppc_decode

    // Byte-lane merge, restricted to implemented bits
    function automatic logic [15:0] ppc_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0]  strb,
                                             input logic [15:0] impl);
        logic [15:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}} & impl;
        return ((old_v & ~lanes) | (new_v & lanes)) & impl;
    endfunction : ppc_merge

endpackage : ppc_pkg
`default_nettype wire

// ### tb/ppc_cc_model.sv
`timescale 1ns/10ps
`default_nettype none
module ppc_cc_model (
    input  wire logic        clk,
    input  wire logic [15:0] p2_pin_out,
    input  wire logic [15:0] p2_pin_oe_n,
    input  wire logic [15:0] port3_pin_out,
    input  wire logic [15:0] port3_pin_oe_n,
    output logic      [15:0] p2_pin_in,
    output logic      [15:0] port3_pin_in,
    output logic      [15:0] compare_strobe,
    output logic      [15:0] cc_mode3,
    output logic      [15:0] cc_overflow
);
    logic [15:0] ext_val;
    logic [15:0] ext_en;

    initial begin
        ext_val        = 16'h0000;
        ext_en         = 16'h0000;
        compare_strobe = 16'h0000;
        cc_mode3       = 16'h0000;
        cc_overflow    = 16'h0000;
    end

    // board off driven lines
    // Undriven lines sit at the pull-up, never at a stale level
    always_comb begin
        p2_pin_in = (~p2_pin_oe_n & p2_pin_out)
                  | (p2_pin_oe_n & ((ext_en & ext_val) | ~ext_en));
        port3_pin_in = (~port3_pin_oe_n & port3_pin_out) | port3_pin_oe_n;
    end

    // Called right after an edge; strobe held for n sampling edges
    task automatic fire(input logic [15:0] m, input logic [15:0] m3,
                        input logic [15:0] ov, input int n);
        compare_strobe <= m;
        cc_mode3       <= m3;
        cc_overflow    <= ov;
        repeat (n) @(posedge clk);
        compare_strobe <= 16'h0000;
    endtask : fire
endmodule : ppc_cc_model
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clk;
    logic        sys_rst;
    logic [17:0] s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [17:0] s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic [15:0] p2_in, p2_out, p2_oe_n, port3_in, port3_out, port3_oe_n;
    logic [15:0] strobe, mode3, ovf, alt_in, alt_rb, alt_out, irq_s;
    logic [7:0]  fast_irq;
    logic        t7_in;
    int          n_errors;
    int          samples_checked;

    ppc_top ppc_top_i (.clk(clk), .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .p2_pin_in(p2_in), .p2_pin_out(p2_out), .p2_pin_oe_n(p2_oe_n),
        .port3_pin_in(port3_in), .port3_pin_out(port3_out), .port3_pin_oe_n(port3_oe_n),
        .compare_strobe(strobe), .cc_mode3(mode3), .cc_overflow(ovf),
        .alt_pin_in(alt_in), .alt_latch_readback(alt_rb), .alt_out_line(alt_out),
        .ext_irq_sample(irq_s), .fast_ext_irq_input(fast_irq), .timer7_count_input(t7_in));

    ppc_cc_model ppc_cc_model_i (.clk(clk), .p2_pin_out(p2_out), .p2_pin_oe_n(p2_oe_n),
        .port3_pin_out(port3_out), .port3_pin_oe_n(port3_oe_n), .p2_pin_in(p2_in),
        .port3_pin_in(port3_in), .compare_strobe(strobe), .cc_mode3(mode3),
        .cc_overflow(ovf));

    always #25 clk = ~clk;

    task automatic stop_test();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : chk

    task automatic give_up(input logic ok);
        if (!ok) begin
            n_errors++;
            stop_test();
        end
    endtask : give_up

    // Clash lines are strobed (mode 1) on the edge that performs the write
    task automatic wr(input logic [15:0] idx, input logic [15:0] d, input logic [3:0] st,
                      input logic [15:0] clash, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        logic b_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        b_ok  = 1'b0;
        s_axi_awaddr  <= {idx, 2'b00};
        s_axi_wdata   <= {16'h0000, d};
        s_axi_wstrb   <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        for (int k = 0; k < 20 && !(aw_ok && w_ok); k++) begin
            @(posedge clk);
            if (s_axi_awready && !aw_ok) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !w_ok) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        give_up(aw_ok && w_ok);
        s_axi_bready <= 1'b1;
        if (clash !== 16'h0000) begin
            ppc_cc_model_i.fire(clash, 16'h0000, 16'h0000, 1);
        end
        for (int k = 0; k < 20 && !b_ok; k++) begin
            @(posedge clk);
            b_ok = s_axi_bvalid;
        end
        give_up(b_ok);
        s_axi_bready <= 1'b0;
        chk("bresp", {14'h0, er}, {14'h0, s_axi_bresp});
    endtask : wr

    task automatic rd(input logic [15:0] idx, input logic [15:0] e, input logic [1:0] er);
        logic ok;
        ok = 1'b0;
        s_axi_araddr  <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        for (int k = 0; k < 20 && !ok; k++) begin
            @(posedge clk);
            ok = s_axi_arready;
        end
        give_up(ok);
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b1;
        ok = 1'b0;
        for (int k = 0; k < 20 && !ok; k++) begin
            @(posedge clk);
            ok = s_axi_rvalid;
        end
        give_up(ok);
        s_axi_rready <= 1'b0;
        chk("rresp", {14'h0, er}, {14'h0, s_axi_rresp});
        chk("rdata_hi", 16'h0000, s_axi_rdata[31:16]);
        chk("rdata", e, s_axi_rdata[15:0]);
    endtask : rd

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        n_errors = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk("port3_oe_n", 16'hFFFF, port3_oe_n);
        chk("p2_out", 16'h0000, p2_out);
        rd(ppc_pkg::IDX_PORT3_DIR, ppc_pkg::RST_PORT3_DIR, ppc_pkg::RESP_OKAY);
        rd(ppc_pkg::IDX_PORT3_OD, ppc_pkg::RST_PORT3_OD, ppc_pkg::RESP_OKAY);
        rd(ppc_pkg::IDX_P2_DIR, ppc_pkg::RST_P2_DIR, ppc_pkg::RESP_OKAY);
        rd(ppc_pkg::IDX_P2_OD, ppc_pkg::RST_P2_OD, ppc_pkg::RESP_OKAY);
        rd(16'h0001, 16'h0000, ppc_pkg::RESP_SLVERR);
        wr(16'h0001, 16'hFFFF, 4'hF, 16'h0000, ppc_pkg::RESP_SLVERR);
        // Second port: unimplemented bits and drive modes
        wr(ppc_pkg::IDX_PORT3_DIR, 16'hFFFF, 4'hF, 16'h0000, ppc_pkg::RESP_OKAY);
        wr(ppc_pkg::IDX_PORT3_OD, 16'hFFFF, 4'hF, 16'h0000, ppc_pkg::RESP_OKAY);
        wr(ppc_pkg::IDX_PORT3_DATA, 16'hFFFF, 4'hF, 16'h0000, ppc_pkg::RESP_OKAY);
        rd(ppc_pkg::IDX_PORT3_DIR, 16'hBFFF, ppc_pkg::RESP_OKAY);
        rd(ppc_pkg::IDX_PORT3_OD, 16'h2FFF, ppc_pkg::RESP_OKAY);
        rd(ppc_pkg::IDX_PORT3_DATA, 16'hBFFF, ppc_pkg::RESP_OKAY);
        chk("port3_out", 16'hBFFF, port3_out);
        chk("port3_oe_n", 16'h6FFF, port3_oe_n);
        wr(ppc_pkg::IDX_PORT3_DATA, 16'h0000, 4'hF, 16'h0000, ppc_pkg::RESP_OKAY);
        chk("port3_oe_n", 16'h4000, port3_oe_n);
        wr(ppc_pkg::IDX_PORT3_DIR, 16'h0000, 4'hF, 16'h0000, ppc_pkg::RESP_OKAY);
        chk("port3_oe_n", 16'hFFFF, port3_oe_n);
        // Released lines read the pull-up once through the synchroniser
        repeat (3) @(posedge clk);
        rd(ppc_pkg::IDX_PORT3_DATA, 16'hBFFF, ppc_pkg::RESP_OKAY);
        // External capture with lines left as inputs
        ppc_cc_model_i.ext_en  <= 16'hFFFF;
        ppc_cc_model_i.ext_val <= 16'hC396;
        repeat (8) @(posedge clk);
        chk("alt_in", 16'hC396, alt_in);
        chk("irq_sample", 16'hC396, irq_s);
        chk("fast_irq", 16'h00C3, {8'h00, fast_irq});
        chk("t7_in", 16'h0001, {15'h0, t7_in});
        rd(ppc_pkg::IDX_P2_DATA, 16'hC396, ppc_pkg::RESP_OKAY);
        // Lines as outputs: capture sees the latch
        ppc_cc_model_i.ext_en <= 16'h0000;
        wr(ppc_pkg::IDX_P2_DIR, 16'hFFFF, 4'hF, 16'h0000, ppc_pkg::RESP_OKAY);
        wr(ppc_pkg::IDX_P2_DATA, 16'h25A5, 4'hF, 16'h0000, ppc_pkg::RESP_OKAY);
        chk("alt_in", 16'h25A5, alt_in);
        chk("t7_in", 16'h0000, {15'h0, t7_in});
        chk("p2_oe_n", 16'h0000, p2_oe_n);
        wr(ppc_pkg::IDX_P2_OD, 16'hFFFF, 4'hF, 16'h0000, ppc_pkg::RESP_OKAY);
        chk("p2_oe_n", 16'h25A5, p2_oe_n);
        wr(ppc_pkg::IDX_P2_OD, 16'h0000, 4'hF, 16'h0000, ppc_pkg::RESP_OKAY);
        // Three back-to-back mode 1 toggles on every channel
        fork
            ppc_cc_model_i.fire(16'hFFFF, 16'h0000, 16'h0000, 3);
            begin
                @(posedge clk);
                chk("alt_out", 16'hDA5A, alt_out);
            end
        join
        @(posedge clk);
        chk("latch_rb", 16'hDA5A, alt_rb);
        chk("p2_out", 16'hDA5A, p2_out);
        repeat (5) @(posedge clk);
        chk("latch_rb", 16'hDA5A, alt_rb);
        fork
            ppc_cc_model_i.fire(16'h00FF, 16'hFFFF, 16'h000F, 1);
            begin
                @(posedge clk);
                chk("alt_out", 16'h00F0, alt_out);
            end
        join
        @(posedge clk);
        chk("latch_rb", 16'hDAF0, alt_rb);
        // CPU write against a strobe in the same cycle, low lane only
        wr(ppc_pkg::IDX_P2_DATA, 16'h00FF, 4'hF, 16'h0000, ppc_pkg::RESP_OKAY);
        wr(ppc_pkg::IDX_P2_DATA, 16'hFF00, 4'h1, 16'h0F0F, ppc_pkg::RESP_OKAY);
        chk("p2_out", 16'h0F00, p2_out);
        stop_test();
    end

    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
